// ---- design/uoc_pkg.sv ----
package uoc_pkg;
    // ==========================================
    // Register map (byte offsets)
    localparam logic [11:0] OFS_CHIPCFG = 12'h000;
    localparam logic [11:0] OFS_SESSCTL = 12'h004;
    localparam logic [11:0] OFS_INDEX = 12'h008;
    localparam logic [11:0] OFS_ALLOCSTAT = 12'h00c;
    localparam logic [7:0] IDX_WIN_PAGE = 8'h41;
    localparam logic [3:0] NIDX_WIN_PAGE = 4'h5;
    // ==========================================
    // Field positions and reset values
    localparam int CFG_W = 11;
    localparam int CFG_GOOD_BIT = 16;
    localparam int CFG_FREQOK_BIT = 17;
    localparam logic [10:0] CFG_RST = 11'h060;
    localparam int SESS_SW_BIT = 0;
    localparam int SESS_IN_BIT = 1;
    localparam int SESS_HOST_BIT = 2;
    localparam int SESS_VBUS_BIT = 3;
    localparam int FIFO_DBL_BIT = 16;
    localparam logic [3:0] FREQ_MIN = 4'h1;
    localparam logic [3:0] FREQ_MAX = 4'h9;
    // ==========================================
    // Endpoint FIFO RAM
    localparam int NUM_EP = 5;
    localparam int FIFO_RAM_BYTES = 4096;
    localparam logic [10:0] EP0_FIFO_BYTES = 11'h040;
    // ==========================================
    // Timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int PLL_LOCK_NS = 10000;
    localparam int PLL_LOCK_CYC = (PLL_LOCK_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ==========================================
    // Types
    typedef struct packed {
        logic phyPllOn;
        logic vbusDetectEn;
        logic sessionEndDetectEn;
        logic dataPolarity;
        logic otgPowerDown;
        logic phyPowerDown;
        logic refClockSelect;
        logic [3:0] refFreqCode;
    } uoc_phy_cfg_s;
    typedef struct packed {
        logic hit;
        logic [2:0] ep;
        logic [1:0] word;
    } uoc_epsel_s;
    typedef enum logic [1:0] {
        SESS_OFF,
        SESS_HOST,
        SESS_PERIPH
    } uoc_sess_e;
endpackage : uoc_pkg

// ---- design/uoc_phy_setup.sv ----
`timescale 1ns/1ps
// Function
// [R1] Select bit 0 external pin, 1 PLL aux
// [R2] Reference runs at an allowed frequency
// [R3] Frequency code 1h..9h tells PHY PLL input
// [R4] Bus interface on divided system clock
// [R5] Indexed endpoint window at 410h-41Fh
// [R6] Non-indexed endpoint slots 500h-54Fh
// [R7] Software orders PHY init steps
// [R8] Software sets normal PHY power bits
// [R9] Software waits for PHY clock good
// [R10] Software routes supply enable pin
// [R11] Supply enable high as host in session
// [R12] Supply enable low in peripheral role
// [R13] Supply enable driven by hardware only
// [R14] One shared 4K endpoint FIFO RAM
// [R15] Four FIFO registers per endpoint
// [R16] Endpoint 0 fixed 64 bytes at 0
// [R17] Software keeps FIFO regions disjoint
// [R18] Prefer external pin for odd PLL rates
// [R19] Session from VBUS sense or software bit
// [R20] Role from ID pin on session entry
// [R21] Unsupported frequency code blocks clock good
module uoc_phy_setup
    import uoc_pkg::*;
#(
    parameter int FIFO_BYTES = FIFO_RAM_BYTES
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // AXI4-Lite slave
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // PHY side
    output uoc_phy_cfg_s phyCfg,
    input wire logic phyPllLocked,
    // Cable side pins
    input wire logic vbusSense,
    input wire logic roleIdPin,
    output logic vbusSupplyEnableOut
);
    // ==========================================
    // State
    uoc_phy_cfg_s cfgQ;
    logic sessSwQ;
    logic [2:0] indexQ;
    logic [10:0] maxPktQ [1:NUM_EP-1][0:1];
    logic [11:0] fifoStartQ [1:NUM_EP-1][0:1];
    logic fifoDblQ [1:NUM_EP-1][0:1];
    logic [7:0] allocErrQ;
    logic [7:0] allocErrD;
    logic [11:0] lockCntQ;
    logic clockGoodQ;
    uoc_sess_e sessQ;
    uoc_sess_e sessD;
    logic [11:0] awAddrQ;
    logic [31:0] wDataQ;
    logic [3:0] wStrbQ;
    logic [31:0] wrVal;
    logic freqOk;
    logic inSession;

    // ==========================================
    // Helpers
    // Index values past the last endpoint leave the indexed window unmapped
    function automatic uoc_epsel_s epDecode(input logic [11:0] a, input logic [2:0] idx);
        uoc_epsel_s s;
        s = '0;
        s.word = a[3:2];
        if (a[11:4] == IDX_WIN_PAGE) begin
            s.hit = (idx < 3'(NUM_EP)); // [R5]
            s.ep = idx;
        end else if (a[11:8] == NIDX_WIN_PAGE && a[7:4] < 4'(NUM_EP)) begin
            s.hit = 1'b1; // [R6]
            s.ep = a[6:4];
        end
        return s;
    endfunction : epDecode

    // Byte strobes merge into the current register value
    function automatic logic [31:0] byteMerge(input logic [31:0] o, input logic [31:0] n, input logic [3:0] st);
        logic [31:0] r;
        r = o;
        for (int b = 0; b < 4; b++) begin
            if (st[b]) begin
                r[b*8 +: 8] = n[b*8 +: 8];
            end
        end
        return r;
    endfunction : byteMerge

    function automatic logic [31:0] regRead(input logic [11:0] a);
        uoc_epsel_s s;
        logic [31:0] r;
        s = epDecode(a, indexQ);
        r = '0;
        if (a == OFS_CHIPCFG) begin
            r[CFG_W-1:0] = cfgQ;
            r[CFG_GOOD_BIT] = clockGoodQ;
            r[CFG_FREQOK_BIT] = freqOk;
        end else if (a == OFS_SESSCTL) begin
            r[SESS_SW_BIT] = sessSwQ;
            r[SESS_IN_BIT] = inSession;
            r[SESS_HOST_BIT] = (sessQ == SESS_HOST);
            r[SESS_VBUS_BIT] = vbusSupplyEnableOut;
        end else if (a == OFS_INDEX) begin
            r[2:0] = indexQ;
        end else if (a == OFS_ALLOCSTAT) begin
            r[7:0] = allocErrQ;
        end else if (s.hit && s.ep == 3'h0) begin
            // Endpoint 0 is fixed: 64 bytes at start address 0
            r[10:0] = s.word[0] ? 11'h0 : EP0_FIFO_BYTES; // [R16]
        end else if (s.hit) begin
            if (s.word[0]) begin
                r[11:0] = fifoStartQ[s.ep][s.word[1]]; // [R15]
                r[FIFO_DBL_BIT] = fifoDblQ[s.ep][s.word[1]];
            end else begin
                r[10:0] = maxPktQ[s.ep][s.word[1]];
            end
        end
        return r;
    endfunction : regRead

    function automatic logic addrMapped(input logic [11:0] a, input logic [2:0] idx);
        uoc_epsel_s s;
        s = epDecode(a, idx);
        return (a == OFS_CHIPCFG) || (a == OFS_SESSCTL) || (a == OFS_INDEX) || (a == OFS_ALLOCSTAT) || s.hit;
    endfunction : addrMapped

    // ==========================================
    // Decode
    assign freqOk = (cfgQ.refFreqCode >= FREQ_MIN) && (cfgQ.refFreqCode <= FREQ_MAX); // [R3] [R21]
    assign inSession = vbusSense | sessSwQ; // [R19]
    // A write commits once address and data are both held; readies stay low until the response is taken
    wire logic wrFire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
    // Procedural so the merge sees every register that the read function touches
    always_comb begin
        wrVal = byteMerge(regRead(awAddrQ), wDataQ, wStrbQ);
    end
    wire logic wrOk = addrMapped(awAddrQ, indexQ);
    wire uoc_epsel_s wrSel = epDecode(awAddrQ, indexQ);
    wire logic wrEp = wrFire && wrSel.hit && (wrSel.ep != 3'h0);
    wire logic pllReady = freqOk && cfgQ.phyPllOn && !cfgQ.phyPowerDown && phyPllLocked;

    // Allocation check against the shared RAM and the fixed endpoint 0 block
    // Overlap between endpoints is left to software; only the RAM top and the endpoint 0 block are checked
    always_comb begin
        allocErrD = '0;
        for (int e = 1; e < NUM_EP; e++) begin
            for (int d = 0; d < 2; d++) begin
                if (maxPktQ[e][d] != 11'h0) begin
                    allocErrD[(e-1) + 4*d] = (fifoStartQ[e][d] < 12'(EP0_FIFO_BYTES))
                        || ((14'(fifoStartQ[e][d]) + (14'(maxPktQ[e][d]) << fifoDblQ[e][d]))
                            > 14'(FIFO_BYTES)); // [R14]
                end
            end
        end
    end

    // Session entry picks the role once; a grounded ID pin means host
    always_comb begin
        sessD = sessQ;
        case (sessQ)
            SESS_OFF: begin
                if (inSession) begin
                    sessD = roleIdPin ? SESS_PERIPH : SESS_HOST; // [R20]
                end
            end
            default: begin
                if (!inSession) begin
                    sessD = SESS_OFF;
                end
            end
        endcase
    end

    // ==========================================
    // AXI4-Lite handshakes (bus side runs on the divided system clock)
    always_ff @(posedge clk_sys) begin // [R4]
        if (!rst_n) begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
            awAddrQ <= '0;
            wDataQ <= '0;
            wStrbQ <= '0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awready <= 1'b0;
                awAddrQ <= {s_axi_awaddr[11:2], 2'b00};
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wready <= 1'b0;
                wDataQ <= s_axi_wdata;
                wStrbQ <= s_axi_wstrb;
            end
            if (wrFire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wrOk ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= regRead({s_axi_araddr[11:2], 2'b00});
            s_axi_rresp <= addrMapped({s_axi_araddr[11:2], 2'b00}, indexQ) ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // ==========================================
    // Configuration registers
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            cfgQ <= CFG_RST;
            sessSwQ <= 1'b0;
            indexQ <= '0;
        end else if (wrFire && awAddrQ == OFS_CHIPCFG) begin
            cfgQ <= wrVal[CFG_W-1:0];
        end else if (wrFire && awAddrQ == OFS_SESSCTL) begin
            sessSwQ <= wrVal[SESS_SW_BIT];
        end else if (wrFire && awAddrQ == OFS_INDEX) begin
            indexQ <= wrVal[2:0];
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            for (int e = 1; e < NUM_EP; e++) begin
                for (int d = 0; d < 2; d++) begin
                    maxPktQ[e][d] <= '0;
                    fifoStartQ[e][d] <= '0;
                    fifoDblQ[e][d] <= 1'b0;
                end
            end
        end else if (wrEp && wrSel.word[0]) begin
            fifoStartQ[wrSel.ep][wrSel.word[1]] <= wrVal[11:0]; // [R15]
            fifoDblQ[wrSel.ep][wrSel.word[1]] <= wrVal[FIFO_DBL_BIT];
        end else if (wrEp) begin
            maxPktQ[wrSel.ep][wrSel.word[1]] <= wrVal[10:0];
        end
    end

    // ==========================================
    // PHY outputs, clock good and supply enable
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            phyCfg <= CFG_RST;
            lockCntQ <= '0;
            clockGoodQ <= 1'b0;
            allocErrQ <= '0;
            sessQ <= SESS_OFF;
            vbusSupplyEnableOut <= 1'b0;
        end else begin
            // The clock mux itself sits in the clock tree; only its select leaves here
            phyCfg <= cfgQ; // [R1]
            allocErrQ <= allocErrD;
            sessQ <= sessD;
            // Driven from session state alone so software cannot force the pump
            vbusSupplyEnableOut <= (sessD == SESS_HOST); // [R11] [R12] [R13]
            // Settling wait keeps good low through PLL lock chatter
            if (!pllReady) begin
                lockCntQ <= '0;
                clockGoodQ <= 1'b0; // [R21]
            end else if (lockCntQ == 12'(PLL_LOCK_CYC)) begin
                clockGoodQ <= 1'b1;
            end else begin
                lockCntQ <= lockCntQ + 12'h1;
            end
        end
    end

    // ==========================================
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sequence sHostEntry;
        !inSession ##1 (inSession && !roleIdPin);
    endsequence

    chk_sel_follows_cfg: assert property (##1 phyCfg.refClockSelect == $past(cfgQ.refClockSelect)) // [R1]
        else $error("reference select not following register");
    chk_host_drives_vbus: assert property (sHostEntry |=> vbusSupplyEnableOut) // [R11]
        else $error("host session without supply enable");
    chk_periph_no_vbus: assert property ((sessQ == SESS_PERIPH) |=> !vbusSupplyEnableOut || sessQ == SESS_HOST) // [R12]
        else $error("supply enable high as peripheral");
    chk_vbus_off_idle: assert property (!inSession |=> !vbusSupplyEnableOut) // [R13] [R19]
        else $error("supply enable high out of session");
    chk_role_latched: assert property ((sessQ == SESS_HOST && inSession) |=> sessQ == SESS_HOST) // [R20]
        else $error("role changed inside a session");
    chk_bad_freq_good: assert property (!freqOk |=> !clockGoodQ) // [R21]
        else $error("clock good with unsupported frequency");
    chk_good_wait: assert property ($rose(clockGoodQ) |-> $past(pllReady, 2) && lockCntQ == 12'(PLL_LOCK_CYC))
        else $error("clock good before settling count");
    chk_ep0_fixed: assert property ((s_axi_arvalid && s_axi_arready && s_axi_araddr[11:2] == 10'h140)
        |=> s_axi_rdata[10:0] == EP0_FIFO_BYTES) // [R16] [R6]
        else $error("endpoint 0 size not fixed");
    chk_write_resp: assert property (wrFire |=> s_axi_bvalid ##0 (s_axi_bresp == RESP_OKAY) == $past(wrOk)) // [R5]
        else $error("write response mismatch");
    chk_alloc_bound: assert property ((fifoStartQ[1][0] == 12'hfc0 && maxPktQ[1][0] == 11'h200) |=> allocErrQ[0]) // [R14]
        else $error("overflow of shared RAM not flagged");
    chk_fifo_store: assert property ((wrEp && wrSel.word == 2'h1) ##1 !wrFire
        |-> fifoStartQ[$past(wrSel.ep)][0] == $past(wrVal[11:0])) // [R15]
        else $error("fifo start address not stored");
    chk_vbus_is_host: assert property (vbusSupplyEnableOut == (sessQ == SESS_HOST)) // [R11] [R12] [R13]
        else $error("supply enable not matching host session");
    chk_index_window: assert property ((s_axi_arvalid && s_axi_arready && s_axi_araddr[11:4] == IDX_WIN_PAGE
        && indexQ >= 3'(NUM_EP)) |=> s_axi_rresp == RESP_SLVERR) // [R5]
        else $error("indexed window mapped for missing endpoint");
    chk_sw_session: assert property ((sessQ == SESS_OFF && sessSwQ && roleIdPin)
        |=> sessQ == SESS_PERIPH) // [R19] [R20]
        else $error("software session with floating pin not peripheral");
    chk_good_needs_lock: assert property ((!phyPllLocked || !cfgQ.phyPllOn) |=> !clockGoodQ) // [R21]
        else $error("clock good without running locked PLL");
endmodule : uoc_phy_setup

// ---- tb/uoc_cable_partner.sv ----
`timescale 1ns/1ps
// ==========================================
// Cable partner and PHY behaviour
module uoc_cable_partner
    import uoc_pkg::*;
#(
    parameter int LOCK_CYC = 40
) (
    // Clock
    input wire logic clk_sys,
    // Scenario controls
    input wire logic plugIsHost,
    input wire logic powerOn,
    // PHY and cable
    input wire uoc_phy_cfg_s phyCfg,
    output logic phyPllLocked,
    output logic vbusSense,
    output logic roleIdPin
);
    int lockCnt = 0;
    wire logic pllRun;
    // The PHY PLL only locks on a supported input rate
    assign pllRun = phyCfg.phyPllOn && !phyCfg.phyPowerDown && (phyCfg.refFreqCode inside {[4'h1:4'h9]});
    // Host plug grounds the pin, a peripheral plug leaves it pulled up
    assign roleIdPin = !plugIsHost;
    // Unpowered cable sits at the pull-down level
    assign vbusSense = powerOn;
    always @(posedge clk_sys) begin
        lockCnt <= pllRun ? lockCnt + 1 : 0;
    end
    assign phyPllLocked = pllRun && (lockCnt >= LOCK_CYC);
endmodule : uoc_cable_partner

// ---- tb/testbench.sv ----
`timescale 1ns/1ps
module testbench;
    import uoc_pkg::*;
    // ==========================================
    // Stimulus and observation
    logic clk_sys = 1'b0, rst_n = 1'b0;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hf;
    logic awready, wready, bvalid, arready, rvalid, phyPllLocked, vbusSense, roleIdPin, vbusSupplyEnableOut;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata, v, alloc;
    uoc_phy_cfg_s phyCfg;
    logic plugIsHost = 1'b0, powerOn = 1'b0, host, useSw, dbl;
    int fails = 0, totalChecks = 0, cycles = 0, c, ep, mp, st;

    always #2.5 clk_sys = ~clk_sys;

    uoc_phy_setup #(.FIFO_BYTES(FIFO_RAM_BYTES)) u_uoc_phy_setup (.clk_sys(clk_sys), .rst_n(rst_n),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .phyCfg(phyCfg), .phyPllLocked(phyPllLocked), .vbusSense(vbusSense),
        .roleIdPin(roleIdPin), .vbusSupplyEnableOut(vbusSupplyEnableOut));
    uoc_cable_partner u_uoc_cable_partner (.clk_sys(clk_sys), .plugIsHost(plugIsHost), .powerOn(powerOn),
        .phyCfg(phyCfg), .phyPllLocked(phyPllLocked), .vbusSense(vbusSense), .roleIdPin(roleIdPin));

    // ==========================================
    // Expectations, comparisons and verdict
    function automatic logic freq_ok(input int code);
        return code >= 1 && code <= 9;
    endfunction : freq_ok
    function automatic logic fifo_err(input int start, input int pkt, input logic dbl2);
        return pkt != 0 && (start < 64 || start + pkt * (dbl2 ? 2 : 1) > FIFO_RAM_BYTES);
    endfunction : fifo_err
    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp, input string what);
        totalChecks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_word
    task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp, input string what);
        totalChecks++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: %s resp %h exp %h", $time, what, got, exp);
        end
    endtask : chk_resp
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", totalChecks, fails);
        if (fails == 0 && totalChecks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : give_verdict
    // ==========================================
    // Bus master: waits are cut short only by the global timeout
    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (1) begin
            @(posedge clk_sys);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        bready <= 1'b0;
        chk_resp(bresp, er, $sformatf("write %h", a));
        // One idle edge keeps the next call from driving bready twice in a time step
        @(posedge clk_sys);
    endtask : wr
    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        while (1) begin
            @(posedge clk_sys);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        rready <= 1'b0;
        chk_word(rdata, ed, $sformatf("read %h", a));
        chk_resp(rresp, er, $sformatf("read %h", a));
        @(posedge clk_sys);
    endtask : rd
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fails++;
            $display("mismatch at %0t: timeout", $time);
            give_verdict();
        end
    end
    // ==========================================
    // Main sequence
    initial begin
        void'($urandom(9432));
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        rd(OFS_CHIPCFG, 32'h60, RESP_OKAY);
        chk_word({21'h0, phyCfg}, {21'h0, CFG_RST}, "phy cfg reset");
        $display("test reset done");
        for (c = 0; c < 16; c++) begin
            v = 32'h380 | 32'(c) | 32'(($urandom % 2) * 16);
            wr(OFS_CHIPCFG, v, RESP_OKAY);
            rd(OFS_CHIPCFG, v | {14'h0, freq_ok(c), 17'h0}, RESP_OKAY);
            chk_word({21'h0, phyCfg}, v, "phy cfg");
        end
        $display("test freq codes done");
        c = 1 + $urandom % 9;
        v = 32'h780 | 32'(c) | 32'(($urandom % 2) * 16);
        wr(OFS_CHIPCFG, v, RESP_OKAY);
        rd(OFS_CHIPCFG, v | 32'h20000, RESP_OKAY);
        repeat (PLL_LOCK_CYC + 80) @(posedge clk_sys);
        rd(OFS_CHIPCFG, v | 32'h30000, RESP_OKAY);
        wr(OFS_CHIPCFG, 32'h780, RESP_OKAY);
        rd(OFS_CHIPCFG, 32'h780, RESP_OKAY);
        // Partial strobe: only the low byte changes, the PLL and detect enable bits stay
        wstrb <= 4'h1;
        wr(OFS_CHIPCFG, 32'h5, RESP_OKAY);
        wstrb <= 4'hf;
        rd(OFS_CHIPCFG, 32'h20705, RESP_OKAY);
        $display("test clock good done");
        for (c = 0; c < 4; c++) begin
            host = c[0];
            useSw = c[1];
            plugIsHost <= host; // Supply pin assumed routed to the controller
            @(posedge clk_sys);
            if (useSw) wr(OFS_SESSCTL, 32'h1, RESP_OKAY);
            else powerOn <= 1'b1;
            repeat (8) @(posedge clk_sys);
            chk_word({31'h0, vbusSupplyEnableOut}, {31'h0, host}, "supply enable");
            plugIsHost <= !host;
            repeat (8) @(posedge clk_sys);
            chk_word({31'h0, vbusSupplyEnableOut}, {31'h0, host}, "role held");
            rd(OFS_SESSCTL, {28'h0, host, host, 1'b1, useSw}, RESP_OKAY);
            powerOn <= 1'b0;
            wr(OFS_SESSCTL, 32'h0, RESP_OKAY);
            repeat (8) @(posedge clk_sys);
            chk_word({31'h0, vbusSupplyEnableOut}, 32'h0, "supply off");
        end
        $display("test session done");
        alloc = 32'h0;
        for (ep = 1; ep < 5; ep++) begin
            mp = 1 + $urandom % 1023;
            st = $urandom % 4096;
            dbl = $urandom % 2;
            alloc[ep - 1] = fifo_err(st, mp, dbl);
            wr(OFS_INDEX, 32'(ep), RESP_OKAY);
            wr(12'h410, 32'(mp), RESP_OKAY);
            wr(12'h414, 32'(st) | {15'h0, dbl, 16'h0}, RESP_OKAY);
            rd(12'h500 + 12'(16 * ep), 32'(mp), RESP_OKAY);
            rd(12'h504 + 12'(16 * ep), 32'(st) | {15'h0, dbl, 16'h0}, RESP_OKAY);
        end
        rd(OFS_ALLOCSTAT, alloc, RESP_OKAY);
        // Corner cases: overflow past the top of the RAM, then a legal region
        wr(OFS_INDEX, 32'h1, RESP_OKAY);
        wr(12'h410, 32'h200, RESP_OKAY);
        wr(12'h414, 32'hfc0, RESP_OKAY);
        alloc[0] = 1'b1;
        rd(OFS_ALLOCSTAT, alloc, RESP_OKAY);
        wr(12'h414, 32'h40, RESP_OKAY);
        alloc[0] = 1'b0;
        rd(OFS_ALLOCSTAT, alloc, RESP_OKAY);
        wr(OFS_INDEX, 32'h0, RESP_OKAY);
        wr(12'h414, 32'h100, RESP_OKAY);
        rd(12'h410, 32'(EP0_FIFO_BYTES), RESP_OKAY);
        rd(12'h504, 32'h0, RESP_OKAY);
        rd(12'h500, 32'(EP0_FIFO_BYTES), RESP_OKAY);
        wr(OFS_INDEX, 32'h5, RESP_OKAY);
        rd(12'h410, 32'h0, RESP_SLVERR);
        rd(12'h550, 32'h0, RESP_SLVERR);
        $display("test fifo alloc done");
        give_verdict();
    end
endmodule : testbench
